/* common/sbpwps_pkg.sv */
package sbpwps_pkg;

   // ----------------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------------
   localparam int          PORT_W      = 6;
   localparam int          REG_W       = 8;
   localparam int          ADR_W       = 8;
   localparam int          DAT_W       = 32;
   localparam int          SYNC_STAGES = 3;

   // ----------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0]  OFS_PIN     = 8'h00;
   localparam logic [7:0]  OFS_DIR     = 8'h04;
   localparam logic [7:0]  OFS_LAT     = 8'h08;
   localparam logic [7:0]  OFS_ANA     = 8'h0c;
   localparam logic [7:0]  OFS_STEER   = 8'h10;

   // ----------------------------------------------------------------------
   // Implemented bits and reset values
   // ----------------------------------------------------------------------
   localparam logic [5:0]  DIR_IMPL    = 6'h37;
   localparam logic [5:0]  LAT_IMPL    = 6'h37;
   localparam logic [5:0]  ANA_IMPL    = 6'h17;
   localparam logic [7:0]  STEER_IMPL  = 8'hcb;
   localparam logic [5:0]  DIR_RST     = 6'h3f;
   localparam logic [5:0]  LAT_RST     = 6'h00;
   localparam logic [5:0]  ANA_RST     = 6'h17;
   localparam logic [7:0]  STEER_RST   = 8'h00;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int          SEL_WFB     = 7;
   localparam int          SEL_WFA     = 6;
   localparam int          SEL_TGATE   = 3;
   localparam int          SEL_LOGIC   = 1;
   localparam int          SEL_OSC     = 0;
   localparam int          PIN_INONLY  = 3;
   localparam int          PIN_TG_ALT  = 4;

endpackage : sbpwps_pkg

/* verilog/sbpwps_pin_sync.sv */
`timescale 1ns/1ps
module sbpwps_pin_sync
#(
   parameter int WIDTH = 6
)
(
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   // ----------------------------------------------------------------------
   // Three stages per pin, level taken once stages two and three agree
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         logic s1_r;
         logic s2_r;
         logic s3_r;
         logic q_r;
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               q_r  <= 1'b0;
            end
            else if (ce_i)
            begin
               s1_r <= async_i[g];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r)
                  q_r <= s3_r;
            end
         end
         assign sync_o[g] = q_r;
      end
   endgenerate

endmodule : sbpwps_pin_sync

/* verilog/sbpwps_out_mux.sv */
`timescale 1ns/1ps
module sbpwps_out_mux
   import sbpwps_pkg::*;
(
   input  wire logic [sbpwps_pkg::PORT_W-1:0] latch_i,
   input  wire logic [sbpwps_pkg::REG_W-1:0]  steer_i,
   input  wire logic                          wfa_i,
   input  wire logic                          wfa_en_i,
   input  wire logic                          wfb_i,
   input  wire logic                          wfb_en_i,
   input  wire logic                          clc_i,
   input  wire logic                          clc_en_i,
   input  wire logic                          osc_i,
   input  wire logic                          osc_en_i,
   output logic      [sbpwps_pkg::PORT_W-1:0] drive_o
);

   // ----------------------------------------------------------------------
   // Which pin each steered function owns
   // ----------------------------------------------------------------------
   wire wfb_on4 = wfb_en_i &  steer_i[SEL_WFB];   // RL15
   wire wfb_on0 = wfb_en_i & ~steer_i[SEL_WFB];   // RL15
   wire wfa_on5 = wfa_en_i &  steer_i[SEL_WFA];   // RL16
   wire wfa_on2 = wfa_en_i & ~steer_i[SEL_WFA];   // RL16
   wire clc_on4 = clc_en_i &  steer_i[SEL_LOGIC]; // RL18
   wire clc_on2 = clc_en_i & ~steer_i[SEL_LOGIC]; // RL18
   wire osc_on5 = osc_en_i &  steer_i[SEL_OSC];   // RL19
   wire osc_on1 = osc_en_i & ~steer_i[SEL_OSC];   // RL19

   // ----------------------------------------------------------------------
   // Highest priority first, latch last; unselected pin keeps its latch
   // ----------------------------------------------------------------------
   assign drive_o[0] = wfb_on0 ? wfb_i : latch_i[0];                  // RL21 RL20 RL8
   assign drive_o[1] = osc_on1 ? osc_i : latch_i[1];                  // RL21 RL20 RL8
   assign drive_o[2] = wfa_on2 ? wfa_i : clc_on2 ? clc_i : latch_i[2]; // RL21 RL8
   assign drive_o[3] = 1'b0;
   assign drive_o[4] = wfb_on4 ? wfb_i : clc_on4 ? clc_i : latch_i[4]; // RL21 RL8
   assign drive_o[5] = wfa_on5 ? wfa_i : osc_on5 ? osc_i : latch_i[5]; // RL21 RL8

endmodule : sbpwps_out_mux

/* verilog/sbpwps_port.sv */
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// RL1: Six-bit bidirectional port, one bit per external pin.
// RL2: Direction bit one turns the pin driver off, pin is input.
// RL3: Direction bit zero turns the driver on and drives the latch value.
// RL4: Bit 3 is input only; its direction bit always reads one.
// RL5: Pin value reads return pin levels; writes update the output latch.
// RL6: Latch writes equal pin value writes; latch reads return stored latch.
// RL7: Writes are read-modify-write: sampled pins, addressed bits replaced, into latch.
// RL8: Enabled peripheral owns its pin instead of the latch; pin stays readable.
// RL9: Analog select bit disables that pin's digital input buffer.
// RL10: Digital reads of an analog pin return zero, register and peripherals.
// RL11: Analog select never gates digital outputs; such pins still drive.
// RL12: Direction bits control drivers even on analog pins.
// RL13: Software should keep analog pins as inputs.
// RL14: Analog select resets to analog; software clears it for digital use.
// RL15: Steering bit 7 puts waveform B on pin 4 if one, pin 0 if zero.
// RL16: Steering bit 6 puts waveform A on pin 5 if one, pin 2 if zero.
// RL17: Steering bit 3 takes timer gate from pin 3 if one, pin 4 if zero.
// RL18: Steering bit 1 puts logic cell on pin 4 if one, pin 2 if zero.
// RL19: Steering bit 0 puts oscillator on pin 5 if one, pin 1 if zero.
// RL20: Steering leaves direction bits alone; overrides follow the selected pin only.
// RL21: Several outputs on one pin: highest priority peripheral wins, latch lowest.
// RL22: Analog select exists only for bits 4, 2, 1, 0; others read zero.
// RL23: Writes act on the strobe's clock edge; pin inputs are synchronised first.
module sbpwps_port
   import sbpwps_pkg::*;
(
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          ce_i,
   input  wire logic                          cyc_i,
   input  wire logic                          stb_i,
   input  wire logic                          we_i,
   input  wire logic [sbpwps_pkg::ADR_W-1:0]  adr_i,
   input  wire logic [3:0]                    sel_i,
   input  wire logic [sbpwps_pkg::DAT_W-1:0]  dat_i,
   output logic      [sbpwps_pkg::DAT_W-1:0]  dat_o,
   output logic                               ack_o,
   input  wire logic [sbpwps_pkg::PORT_W-1:0] pin_in_i,
   output logic      [sbpwps_pkg::PORT_W-1:0] pin_out_o,
   output logic      [sbpwps_pkg::PORT_W-1:0] pin_oe_n_o,
   output logic      [sbpwps_pkg::PORT_W-1:0] pin_digital_o,
   input  wire logic                          waveform_out_a_i,
   input  wire logic                          waveform_out_a_en_i,
   input  wire logic                          waveform_out_b_i,
   input  wire logic                          waveform_out_b_en_i,
   input  wire logic                          logic_cell_output_i,
   input  wire logic                          logic_cell_output_en_i,
   input  wire logic                          numeric_osc_output_i,
   input  wire logic                          numeric_osc_output_en_i,
   output logic                               timer_gate_input_o
);

   import sbpwps_pkg::*;

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   function automatic logic reg_hit
   (
      input logic [ADR_W-1:0] adr,
      input logic [7:0]       ofs
   );
      reg_hit = (adr[ADR_W-1:2] == ofs[ADR_W-1:2]);
   endfunction : reg_hit

   logic [PORT_W-1:0] direction_bits_r;
   logic [PORT_W-1:0] direction_bits_nxt;
   logic [PORT_W-1:0] output_latch_r;
   logic [PORT_W-1:0] output_latch_nxt;
   logic [PORT_W-1:0] analog_select_r;
   logic [PORT_W-1:0] analog_select_nxt;
   logic [REG_W-1:0]  pin_steering_control_r;
   logic [REG_W-1:0]  pin_steering_control_nxt;
   logic              ack_r;
   logic              ack_nxt;
   logic [DAT_W-1:0]  dat_r;
   logic [DAT_W-1:0]  dat_nxt;
   logic [PORT_W-1:0] pin_out_r;
   logic [PORT_W-1:0] oe_n_r;
   logic [PORT_W-1:0] dig_r;
   logic              tgate_r;
   logic [PORT_W-1:0] pin_sync;
   logic [PORT_W-1:0] drive_val;

   wire               hit_pin  = reg_hit(adr_i, OFS_PIN);
   wire               hit_dir  = reg_hit(adr_i, OFS_DIR);
   wire               hit_lat  = reg_hit(adr_i, OFS_LAT);
   wire               hit_ana  = reg_hit(adr_i, OFS_ANA);
   wire               hit_str  = reg_hit(adr_i, OFS_STEER);
   wire               hit_port = hit_pin | hit_lat;

   // ----------------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------------
   // Request taken at the first edge, write done at the edge that sees ack
   wire               bus_req  = cyc_i & stb_i;
   wire               bus_take = bus_req & ~ack_r;
   wire               wr_go    = bus_req & we_i & ack_r;
   wire               lane0    = sel_i[0];
   wire [PORT_W-1:0]  wdat6    = dat_i[PORT_W-1:0];
   wire [REG_W-1:0]   wdat8    = dat_i[REG_W-1:0];

   assign ack_nxt = bus_take;

   // ----------------------------------------------------------------------
   // Pin input path
   // ----------------------------------------------------------------------
   sbpwps_pin_sync
   #(
      .WIDTH (PORT_W)
   )
   u_sync
   (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .async_i (pin_in_i),
      .sync_o  (pin_sync)
   );

   // Analog pins read zero to every digital consumer
   wire [PORT_W-1:0]  pin_rd   = pin_sync & ~analog_select_r;   // RL9 RL10 RL23
   wire               tg_src   = pin_steering_control_r[SEL_TGATE] ?
                                 pin_rd[PIN_INONLY] : pin_rd[PIN_TG_ALT]; // RL17

   // ----------------------------------------------------------------------
   // Register next values
   // ----------------------------------------------------------------------
   assign direction_bits_nxt = (wr_go & hit_dir & lane0) ?
                               ((wdat6 & DIR_IMPL) | ~DIR_IMPL) :          // RL4 RL23
                               direction_bits_r;

   // Unselected lane writes back the sampled pins, as a port write would
   assign output_latch_nxt = (wr_go & hit_port) ?
                             ((lane0 ? wdat6 : pin_rd) & LAT_IMPL) :       // RL5 RL6 RL7
                             output_latch_r;

   assign analog_select_nxt = (wr_go & hit_ana & lane0) ?
                              (wdat6 & ANA_IMPL) :                         // RL22
                              analog_select_r;

   assign pin_steering_control_nxt = (wr_go & hit_str & lane0) ?
                                     (wdat8 & STEER_IMPL) :
                                     pin_steering_control_r;

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------
   wire [REG_W-1:0]   rd_pin   = {2'h0, pin_rd};                // RL5
   wire [REG_W-1:0]   rd_dir   = {2'h0, direction_bits_r};      // RL4
   wire [REG_W-1:0]   rd_lat   = {2'h0, output_latch_r};        // RL6
   wire [REG_W-1:0]   rd_ana   = {2'h0, analog_select_r};       // RL22
   wire [REG_W-1:0]   rd_mux   = hit_pin ? rd_pin :
                                 hit_dir ? rd_dir :
                                 hit_lat ? rd_lat :
                                 hit_ana ? rd_ana :
                                 hit_str ? pin_steering_control_r :
                                 8'h00;

   assign dat_nxt = bus_take ? {{(DAT_W-REG_W){1'b0}}, rd_mux} : dat_r;

   // ----------------------------------------------------------------------
   // Pin output drive
   // ----------------------------------------------------------------------
   sbpwps_out_mux u_mux
   (
      .latch_i  (output_latch_r),
      .steer_i  (pin_steering_control_r),
      .wfa_i    (waveform_out_a_i),
      .wfa_en_i (waveform_out_a_en_i),
      .wfb_i    (waveform_out_b_i),
      .wfb_en_i (waveform_out_b_en_i),
      .clc_i    (logic_cell_output_i),
      .clc_en_i (logic_cell_output_en_i),
      .osc_i    (numeric_osc_output_i),
      .osc_en_i (numeric_osc_output_en_i),
      .drive_o  (drive_val)
   );

   // Driver enable comes from direction alone, never from analog select
   wire [PORT_W-1:0]  oe_n_nxt = direction_bits_r | ~DIR_IMPL;  // RL2 RL3 RL11 RL12 RL20

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         direction_bits_r       <= DIR_RST;
         output_latch_r         <= LAT_RST;
         analog_select_r        <= ANA_RST;   // RL14
         pin_steering_control_r <= STEER_RST;
         ack_r                  <= 1'b0;
         dat_r                  <= '0;
      end
      else if (ce_i)
      begin
         direction_bits_r       <= direction_bits_nxt;
         output_latch_r         <= output_latch_nxt;
         analog_select_r        <= analog_select_nxt;
         pin_steering_control_r <= pin_steering_control_nxt;
         ack_r                  <= ack_nxt;
         dat_r                  <= dat_nxt;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pin_out_r <= '0;
         oe_n_r    <= '1;
         dig_r     <= '0;
         tgate_r   <= 1'b0;
      end
      else if (ce_i)
      begin
         pin_out_r <= drive_val;   // RL1 RL3 RL8
         oe_n_r    <= oe_n_nxt;    // RL2
         dig_r     <= pin_rd;      // RL10
         tgate_r   <= tg_src;      // RL17
      end
   end

   assign ack_o              = ack_r;
   assign dat_o              = dat_r;
   assign pin_out_o          = pin_out_r;
   assign pin_oe_n_o         = oe_n_r;
   assign pin_digital_o      = dig_r;
   assign timer_gate_input_o = tgate_r;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence bus_req_s;
      cyc_i && stb_i && !ack_o && ce_i;
   endsequence

   sequence port_wr_s;
      cyc_i && stb_i && we_i && ack_o && ce_i && hit_port;
   endsequence

   bus_answer_a : assert property (bus_req_s |=> ack_o)
      else $error("bus request not answered in one cycle");

   ack_drop_a : assert property (ack_o && ce_i |=> !ack_o)
      else $error("ack held longer than one cycle");

   latch_write_a : assert property (port_wr_s and lane0 |=> // RL6
      output_latch_r == ($past(wdat6) & LAT_IMPL))
      else $error("port write did not reach the latch");

   latch_rmw_a : assert property (port_wr_s and !lane0 |=> // RL7
      output_latch_r == ($past(pin_rd) & LAT_IMPL))
      else $error("unselected lane did not write back pins");

   pin_read_a : assert property (bus_req_s and !we_i && hit_pin |=> // RL5
      dat_o == {{(DAT_W-PORT_W){1'b0}}, $past(pin_rd)})
      else $error("pin value read does not show pin levels");

   dir_bit3_a : assert property (direction_bits_r[PIN_INONLY] // RL4
      && pin_oe_n_o[PIN_INONLY])
      else $error("input only pin direction not one");

   oe_follow_a : assert property (ce_i |=> // RL2
      pin_oe_n_o == ($past(direction_bits_r) | ~DIR_IMPL))
      else $error("driver enable not following direction bits");

   analog_zero_a : assert property (ce_i |=> // RL10
      (pin_digital_o & $past(analog_select_r)) == '0)
      else $error("analog pin reads nonzero");

   analog_reset_a : assert property ($past(rst_i) |-> // RL14
      analog_select_r == ANA_RST && direction_bits_r == DIR_RST)
      else $error("analog or direction reset value wrong");

   analog_impl_a : assert property ((analog_select_r & ~ANA_IMPL) == '0) // RL22
      else $error("unimplemented analog bit set");

   wave_b_alt_a : assert property (ce_i && waveform_out_b_en_i // RL15
      && pin_steering_control_r[SEL_WFB] |=> pin_out_o[4] == $past(waveform_out_b_i))
      else $error("waveform B not on pin 4");

   wave_a_def_a : assert property (ce_i && waveform_out_a_en_i // RL16
      && !pin_steering_control_r[SEL_WFA] |=> pin_out_o[2] == $past(waveform_out_a_i))
      else $error("waveform A not on pin 2");

   osc_def_a : assert property (ce_i && numeric_osc_output_en_i // RL19
      && !pin_steering_control_r[SEL_OSC] |=> pin_out_o[1] == $past(numeric_osc_output_i))
      else $error("oscillator not on pin 1");

   logic_prio_a : assert property (ce_i && logic_cell_output_en_i // RL18
      && pin_steering_control_r[SEL_LOGIC]
      && !(waveform_out_b_en_i && pin_steering_control_r[SEL_WFB])
      |=> pin_out_o[4] == $past(logic_cell_output_i))
      else $error("logic cell not on pin 4");

   latch_lowest_a : assert property (ce_i // RL21
      && !(waveform_out_b_en_i && !pin_steering_control_r[SEL_WFB])
      |=> pin_out_o[0] == $past(output_latch_r[0]))
      else $error("pin 0 not driven from latch");

   timer_gate_a : assert property (ce_i |=> timer_gate_input_o == // RL17
      ($past(pin_steering_control_r[SEL_TGATE]) ? pin_digital_o[PIN_INONLY]
                                                : pin_digital_o[PIN_TG_ALT]))
      else $error("timer gate from wrong pin");

endmodule : sbpwps_port

/* dv/sbpwps_pad_model.sv */
`timescale 1ns/1ps
module sbpwps_pad_model
   import sbpwps_pkg::*;
(
   input  wire logic [sbpwps_pkg::PORT_W-1:0] pin_out_i,
   input  wire logic [sbpwps_pkg::PORT_W-1:0] pin_oe_n_i,
   input  wire logic [sbpwps_pkg::PORT_W-1:0] ext_i,
   output logic      [sbpwps_pkg::PORT_W-1:0] pad_o
);
   // Driven pins show the device value, released pins the outside level
   assign pad_o = (pin_out_i & ~pin_oe_n_i) | (ext_i & pin_oe_n_i);
endmodule : sbpwps_pad_model

/* dv/sbpwps_tb_top.sv */
`timescale 1ns/1ps
module six_bit_port_with_pin_steering_tb_top;
   import sbpwps_pkg::*;
   typedef struct packed {
      logic [7:0] adr;
      logic [7:0] wd;
      logic [7:0] rd;
      logic [7:0] per;
      logic [5:0] out;
      logic [5:0] oe;
   } sbpwps_row_type;
   // ------------------------------------------------------------
   // Signals and parts
   // ------------------------------------------------------------
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat_w = 32'h0, dat_r, q;
   logic        ack, tg;
   logic [5:0]  pad, pin_out, pin_oe_n, pin_dig, ext = 6'h00;
   logic        wa = 1'b0, wae = 1'b0, wb = 1'b0, wbe = 1'b0;
   logic        lc = 1'b0, lce = 1'b0, no = 1'b0, noe = 1'b0;
   int          n_fail = 0, samples_checked = 0, cycles = 0;
   sbpwps_row_type rows [19] = '{
      '{8'h04, 8'hff, 8'h3f, 8'h00, 6'h00, 6'h3f}, '{8'h0c, 8'hff, 8'h17, 8'h00, 6'h00, 6'h3f},
      '{8'h10, 8'hff, 8'hcb, 8'h00, 6'h00, 6'h3f}, '{8'h20, 8'ha5, 8'h00, 8'h00, 6'h00, 6'h3f},
      '{8'h10, 8'h00, 8'h00, 8'h00, 6'h00, 6'h3f}, '{8'h0c, 8'h00, 8'h00, 8'h00, 6'h00, 6'h3f},
      '{8'h04, 8'h00, 8'h08, 8'h00, 6'h00, 6'h08}, '{8'h08, 8'hff, 8'h37, 8'h00, 6'h37, 6'h08},
      '{8'h08, 8'h00, 8'h00, 8'h00, 6'h00, 6'h08}, '{8'h10, 8'h00, 8'h00, 8'h44, 6'h01, 6'h08},
      '{8'h10, 8'h80, 8'h80, 8'h44, 6'h10, 6'h08}, '{8'h10, 8'h00, 8'h00, 8'h11, 6'h02, 6'h08},
      '{8'h10, 8'h01, 8'h01, 8'h11, 6'h20, 6'h08}, '{8'h10, 8'h00, 8'h00, 8'h88, 6'h04, 6'h08},
      '{8'h10, 8'h40, 8'h40, 8'h88, 6'h20, 6'h08}, '{8'h10, 8'h00, 8'h00, 8'h22, 6'h04, 6'h08},
      '{8'h10, 8'h02, 8'h02, 8'h22, 6'h10, 6'h08}, '{8'h10, 8'h00, 8'h00, 8'ha2, 6'h00, 6'h08},
      '{8'h10, 8'h42, 8'h42, 8'haa, 6'h30, 6'h08}};
   sbpwps_port uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
      .pin_in_i(pad), .pin_out_o(pin_out), .pin_oe_n_o(pin_oe_n), .pin_digital_o(pin_dig),
      .waveform_out_a_i(wa), .waveform_out_a_en_i(wae), .waveform_out_b_i(wb),
      .waveform_out_b_en_i(wbe), .logic_cell_output_i(lc), .logic_cell_output_en_i(lce),
      .numeric_osc_output_i(no), .numeric_osc_output_en_i(noe), .timer_gate_input_o(tg));
   sbpwps_pad_model pads (.pin_out_i(pin_out), .pin_oe_n_i(pin_oe_n), .ext_i(ext), .pad_o(pad));
   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic s);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= {3'h0, s};
      dat_w <= {24'h0, d};
      @(posedge clk_i);
      while (ack !== 1'b1)
      begin
         @(posedge clk_i);
      end
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 1'b1);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h00, 1'b1);
      check(q, exp);
   endtask : rdchk
   task automatic chk_reset();
      check({26'h0, pin_oe_n}, 32'h3f);
      check({26'h0, pin_out}, 32'h00);
      rdchk(OFS_ANA, 32'h17);
      rdchk(OFS_DIR, 32'h3f);
      rdchk(OFS_LAT, 32'h00);
      rdchk(OFS_STEER, 32'h00);
   endtask : chk_reset
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk_reset();
      foreach (rows[i])
      begin
         {wae, wbe, lce, noe, wa, wb, lc, no} <= rows[i].per;
         wr(rows[i].adr, rows[i].wd);
         rdchk(rows[i].adr, {24'h0, rows[i].rd});
         check({26'h0, pin_out}, {26'h0, rows[i].out});
         check({26'h0, pin_oe_n}, {26'h0, rows[i].oe});
      end
      {wae, wbe, lce, noe} <= 4'h0;
      wr(OFS_DIR, 8'hff);
      ext <= 6'h2a;
      repeat (8) @(posedge clk_i);
      rdchk(OFS_PIN, 32'h2a);
      bus(1'b1, OFS_LAT, 8'hff, 1'b0);
      rdchk(OFS_LAT, 32'h22);
      wr(OFS_PIN, 8'h15);
      rdchk(OFS_LAT, 32'h15);
      wr(OFS_ANA, 8'h01);
      wr(OFS_DIR, 8'h3e);
      repeat (8) @(posedge clk_i);
      check({26'h0, pin_out & ~pin_oe_n}, 32'h01);
      rdchk(OFS_PIN, 32'h2a);
      check({26'h0, pin_dig}, 32'h2a);
      wr(OFS_STEER, 8'h08);
      repeat (4) @(posedge clk_i);
      check({31'h0, tg}, 32'h1);
      wr(OFS_STEER, 8'h00);
      repeat (4) @(posedge clk_i);
      check({31'h0, tg}, 32'h0);
      ce <= 1'b0;
      ext <= 6'h15;
      repeat (8) @(posedge clk_i);
      check({26'h0, pin_dig}, 32'h2a);
      ce <= 1'b1;
      repeat (8) @(posedge clk_i);
      check({26'h0, pin_dig}, 32'h14);
      check({31'h0, tg}, 32'h1);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk_reset();
      tally_and_finish();
   end
endmodule : six_bit_port_with_pin_steering_tb_top
